/* File: verilog/scp_consts.vh */
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH
`define SCP_LF 8'h0A
`define SCP_CR 8'h0D
`define SCP_SP 8'h20
`define SCP_COLON 8'h3A
`define SCP_SEMI 8'h3B
`define SCP_COMMA 8'h2C
`define SCP_QMARK 8'h3F
`define SCP_STAR 8'h2A
`define SCP_ASCII0 8'h30
`define SCP_N_SENS 4'h1
`define SCP_N_CORR 4'h2
`define SCP_N_BEAM 4'h3
`define SCP_N_WAV 4'h4
`define SCP_N_AVER 4'h5
`define SCP_N_CURR 4'h6
`define SCP_N_DC 4'h7
`define SCP_N_RANG 4'h8
`define SCP_N_AUTO 4'h9
`define SCP_NODES 9
`define SCP_KW_MAX 4'hC
`define SCP_K_NONE 2'h0
`define SCP_K_NUM 2'h1
`define SCP_K_BOOL 2'h2
`define SCP_S_VAL 2'h0
`define SCP_S_MIN 2'h1
`define SCP_S_MAX 2'h2
`define SCP_S_DEF 2'h3
`define SCP_E_HDR 3'h1
`define SCP_E_PARAM 3'h2
`define SCP_E_SYN 3'h3
`define SCP_E_LEN 3'h4
`define SCP_E_FULL 3'h5
`define SCP_BEAM_MIN 16'h0001
`define SCP_BEAM_MAX 16'h0064
`define SCP_BEAM_DEF 16'h0005
`define SCP_WAV_MIN 16'h0190
`define SCP_WAV_MAX 16'h044C
`define SCP_WAV_DEF 16'h0277
`define SCP_AVER_MIN 16'h0001
`define SCP_AVER_MAX 16'h2710
`define SCP_AVER_DEF 16'h0001
`define SCP_RANG_MIN 16'h0000
`define SCP_RANG_MAX 16'h0007
`define SCP_RANG_DEF 16'h0007
`define SCP_AUTO_DEF 16'h0001
`define SCP_EF_VAL 32
`define SCP_EF_PCNT 48
`define SCP_EF_SEL 50
`define SCP_EF_QRY 52
`define SCP_EF_NODE 53
`define SCP_EF_COM 57
`define SCP_EW 58
`endif

/* File: verilog/scp_parser.v */
`include "scp_consts.vh"

// Summary of operation
// [R01] Keywords match in short form or complete long form.
// [R02] Keyword matching ignores letter case.
// [R03] Any other truncation or extension of a keyword is an error.
// [R04] A colon descends one level in the command tree.
// [R05] Host puts a blank between the last keyword and first parameter.
// [R06] Parameters are separated by commas; the parser splits and counts them.
// [R07] Semicolon starts a new command relative to the previous command's parent.
// [R08] Semicolon then colon restarts at root; other subsystem after bare semicolon errors.
// [R09] Optional nodes match whether present or omitted.
// [R10] A missing optional parameter takes its default value.
// [R11] MIN and MAX set the lowest or highest allowed value.
// [R12] A trailing question mark makes a query returning the present value.
// [R13] A query with MIN or MAX returns the limit, not the value.
// [R14] Host reads each response before sending another query.
// [R15] Line feed ends a string; nothing executes before a terminator.
// [R16] A byte flagged end-or-identify is taken as itself, then followed by an implied line feed.
// [R17] Carriage return followed by line feed is also a terminator.
// [R18] Any terminator resets the keyword path to the root.
// [R19] Common commands start with an asterisk, four or five characters long.
// [R20] Chained common commands execute in received order.
// [R21] Syntax errors drop the command, log an error, skip to terminator.
// [R22] Boolean query answers are always the character 0 or 1.
module scp_parser #(
  parameter QDEPTH = 4,
  parameter QAW = 2
) (
  input wire clk,
  input wire reset_n,
  input wire ce,
  input wire byte_valid,
  input wire [7:0] byte_data,
  input wire byte_eoi,
  output wire in_ready,
  output wire exec_valid,
  output wire exec_common,
  output wire [3:0] exec_node,
  output wire exec_query,
  output wire [15:0] exec_value,
  output wire [1:0] exec_pcount,
  output wire [31:0] exec_code,
  output wire resp_valid,
  output wire [15:0] resp_data,
  output wire err_valid,
  output wire [2:0] err_code,
  output wire [7:0] err_count
);
  localparam S_CMD = 3'h0;
  localparam S_KW = 3'h1;
  localparam S_QRY = 3'h2;
  localparam S_PAR = 3'h3;
  localparam S_CR = 3'h4;
  localparam S_SKIP = 3'h5;
  localparam S_EXEC = 3'h6;

  function [7:0] up;
    input [7:0] ch;
    up = (ch >= 8'h61 && ch <= 8'h7A) ? ch - 8'h20 : ch;
  endfunction

  function is_let;
    input [7:0] ch;
    is_let = ch >= 8'h41 && ch <= 8'h5A;
  endfunction

  function is_dig;
    input [7:0] ch;
    is_dig = ch >= 8'h30 && ch <= 8'h39;
  endfunction

  function [95:0] kw_short;
    input [3:0] n;
    case (n)
      `SCP_N_SENS: kw_short = "SENS";
      `SCP_N_CORR: kw_short = "CORR";
      `SCP_N_BEAM: kw_short = "BEAM";
      `SCP_N_WAV: kw_short = "WAV";
      `SCP_N_AVER: kw_short = "AVER";
      `SCP_N_CURR: kw_short = "CURR";
      `SCP_N_DC: kw_short = "DC";
      `SCP_N_RANG: kw_short = "RANG";
      `SCP_N_AUTO: kw_short = "AUTO";
      default: kw_short = 96'h0;
    endcase
  endfunction

  function [95:0] kw_long;
    input [3:0] n;
    case (n)
      `SCP_N_SENS: kw_long = "SENSE";
      `SCP_N_CORR: kw_long = "CORRECTION";
      `SCP_N_BEAM: kw_long = "BEAMDIAMETER";
      `SCP_N_WAV: kw_long = "WAVELENGTH";
      `SCP_N_AVER: kw_long = "AVERAGE";
      `SCP_N_CURR: kw_long = "CURRENT";
      `SCP_N_DC: kw_long = "DC";
      `SCP_N_RANG: kw_long = "RANGE";
      `SCP_N_AUTO: kw_long = "AUTO";
      default: kw_long = 96'h0;
    endcase
  endfunction

  function [3:0] node_par;
    input [3:0] n;
    case (n)
      `SCP_N_CORR: node_par = `SCP_N_SENS;
      `SCP_N_BEAM: node_par = `SCP_N_CORR;
      `SCP_N_WAV: node_par = `SCP_N_CORR;
      `SCP_N_AVER: node_par = `SCP_N_SENS;
      `SCP_N_DC: node_par = `SCP_N_CURR;
      `SCP_N_RANG: node_par = `SCP_N_DC;
      `SCP_N_AUTO: node_par = `SCP_N_RANG;
      default: node_par = 4'h0;
    endcase
  endfunction

  function node_opt;
    input [3:0] n;
    node_opt = n == `SCP_N_SENS || n == `SCP_N_DC;
  endfunction

  function [1:0] node_kind;
    input [3:0] n;
    case (n)
      `SCP_N_BEAM, `SCP_N_WAV, `SCP_N_AVER, `SCP_N_RANG: node_kind = `SCP_K_NUM;
      `SCP_N_AUTO: node_kind = `SCP_K_BOOL;
      default: node_kind = `SCP_K_NONE;
    endcase
  endfunction

  function [15:0] lim;
    input [3:0] n;
    input [1:0] s;
    case (n)
      `SCP_N_BEAM: lim = s == `SCP_S_MIN ? `SCP_BEAM_MIN :
        s == `SCP_S_MAX ? `SCP_BEAM_MAX : `SCP_BEAM_DEF;
      `SCP_N_WAV: lim = s == `SCP_S_MIN ? `SCP_WAV_MIN :
        s == `SCP_S_MAX ? `SCP_WAV_MAX : `SCP_WAV_DEF;
      `SCP_N_AVER: lim = s == `SCP_S_MIN ? `SCP_AVER_MIN :
        s == `SCP_S_MAX ? `SCP_AVER_MAX : `SCP_AVER_DEF;
      `SCP_N_RANG: lim = s == `SCP_S_MIN ? `SCP_RANG_MIN :
        s == `SCP_S_MAX ? `SCP_RANG_MAX : `SCP_RANG_DEF;
      `SCP_N_AUTO: lim = s == `SCP_S_MIN ? 16'h0000 :
        s == `SCP_S_MAX ? 16'h0001 : `SCP_AUTO_DEF;
      default: lim = 16'h0000;
    endcase
  endfunction

  // Exact short or long spelling, child of the path or of an optional child
  function [3:0] resolve;
    input [3:0] cur;
    input [95:0] b;
    integer i;
    reg [3:0] p;
    begin
      resolve = 4'h0;
      for (i = 1; i <= `SCP_NODES; i = i + 1) begin
        p = node_par(i[3:0]);
        if ((b == kw_short(i[3:0]) || b == kw_long(i[3:0])) && // [R01] [R03]
            (p == cur || (node_opt(p) && node_par(p) == cur))) // [R09]
          resolve = i[3:0];
      end
    end
  endfunction

  reg [2:0] state_q;
  reg [95:0] buf_q;
  reg [3:0] len_q, cur_q, node_q;
  reg com_q, query_q, tany_q, tnum_q, tstop_q, eoi_pend_q;
  reg [1:0] sel_q, pcnt_q;
  reg [15:0] val_q;
  reg [31:0] code_q;
  reg [QAW-1:0] wr_q, rd_q;
  reg [QAW:0] cnt_q;
  reg [`SCP_EW-1:0] q_mem [0:QDEPTH-1];
  reg [15:0] set_q [0:15];
  reg in_ready_q, exec_valid_q, exec_common_q, exec_query_q, resp_valid_q, err_valid_q;
  reg [3:0] exec_node_q;
  reg [15:0] exec_value_q, resp_data_q;
  reg [1:0] exec_pcount_q;
  reg [31:0] exec_code_q;
  reg [2:0] err_code_q;
  reg [7:0] err_count_q;
  integer k;

  wire take = byte_valid & in_ready_q;
  wire go = take | eoi_pend_q;
  wire [7:0] c = up(eoi_pend_q ? `SCP_LF : byte_data); // [R02] [R16]
  wire term = c == `SCP_LF;
  wire ends = c == `SCP_SEMI || term || c == `SCP_CR;
  wire [3:0] hit_w = resolve(cur_q, buf_q);
  wire kw_fin = state_q == S_KW;
  wire com_ok = len_q == 4'h3 || len_q == 4'h4;
  wire append = is_let(c) || is_dig(c) || (com_q && c == `SCP_QMARK);
  wire w_min = buf_q == "MIN" || buf_q == "MINIMUM";
  wire w_max = buf_q == "MAX" || buf_q == "MAXIMUM";
  wire w_def = buf_q == "DEF" || buf_q == "DEFAULT";
  wire w_on = buf_q == "ON";
  wire w_off = buf_q == "OFF";
  wire tok_bad = tany_q & ~tnum_q & ~(w_min | w_max | w_def | w_on | w_off);
  wire [1:0] tok_sel = tnum_q ? `SCP_S_VAL : w_min ? `SCP_S_MIN : // [R11]
    w_max ? `SCP_S_MAX : w_def ? `SCP_S_DEF : `SCP_S_VAL;
  wire [15:0] tok_val = tnum_q ? val_q : {15'h0000, w_on};
  wire par_tok = state_q == S_PAR && tany_q;
  wire first_tok = par_tok && pcnt_q == 2'h0;
  wire [1:0] f_pc = (par_tok && pcnt_q != 2'h3) ? pcnt_q + 2'h1 : pcnt_q;
  wire [1:0] f_sel0 = first_tok ? tok_sel : sel_q;
  wire [1:0] f_sel = (!query_q && !com_q && f_pc == 2'h0) ? `SCP_S_DEF : f_sel0; // [R10]
  wire [15:0] f_val = first_tok ? tok_val : val_q;
  wire [3:0] f_node = (kw_fin && !com_q) ? hit_w : node_q;
  wire [31:0] code_e = (kw_fin && com_q) ? buf_q[31:0] : code_q;
  wire fin_w = go && ends && (kw_fin || state_q == S_QRY || state_q == S_PAR);
  reg [2:0] f_err;

  always @* begin
    if (state_q == S_PAR && tok_bad)
      f_err = `SCP_E_PARAM;
    else if (com_q)
      f_err = (kw_fin && !com_ok) ? `SCP_E_LEN : 3'h0; // [R19]
    else if (f_node == 4'h0 || node_kind(f_node) == `SCP_K_NONE)
      f_err = `SCP_E_HDR; // [R03]
    else
      f_err = 3'h0;
    if (f_err == 3'h0 && cnt_q == QDEPTH[QAW:0])
      f_err = `SCP_E_FULL;
  end

  wire [`SCP_EW-1:0] f_entry = {com_q, f_node, query_q, f_sel, f_pc, f_val, code_e};
  wire [`SCP_EW-1:0] e = q_mem[rd_q];
  wire [3:0] e_node = e[`SCP_EF_NODE +: 4];
  wire [1:0] e_sel = e[`SCP_EF_SEL +: 2];
  wire [15:0] e_val = e[`SCP_EF_VAL +: 16];
  wire e_bool = node_kind(e_node) == `SCP_K_BOOL;
  wire [15:0] e_lim = lim(e_node, e_sel);
  wire [15:0] e_lo = lim(e_node, `SCP_S_MIN);
  wire [15:0] e_hi = lim(e_node, `SCP_S_MAX);
  wire [15:0] s_new = e_sel != `SCP_S_VAL ? e_lim : e_bool ? {15'h0000, e_val != 16'h0000} :
    e_val < e_lo ? e_lo : e_val > e_hi ? e_hi : e_val; // [R11]
  wire [15:0] r_raw = e_sel != `SCP_S_VAL ? e_lim : set_q[e_node]; // [R12] [R13]
  wire [15:0] r_data = e_bool ? {8'h00, `SCP_ASCII0 | {7'h00, r_raw[0]}} : r_raw; // [R22]

  // Queue of parsed commands, held back until the string is terminated
  always @(posedge clk) begin
    if (ce && fin_w && f_err == 3'h0)
      q_mem[wr_q] <= f_entry; // [R15]
  end

  task clr_cmd;
    begin
      buf_q <= 96'h0;
      len_q <= 4'h0;
      com_q <= 1'b0;
      query_q <= 1'b0;
      node_q <= 4'h0;
      sel_q <= `SCP_S_VAL;
      val_q <= 16'h0000;
      pcnt_q <= 2'h0;
      tany_q <= 1'b0;
      tnum_q <= 1'b0;
      tstop_q <= 1'b0;
      code_q <= 32'h0;
    end
  endtask

  task fail;
    input [2:0] code;
    begin
      err_valid_q <= 1'b1; // [R21]
      err_code_q <= code;
      if (err_count_q != 8'hFF)
        err_count_q <= err_count_q + 8'h01;
      clr_cmd;
      state_q <= S_SKIP;
    end
  endtask

  task terminate;
    begin
      clr_cmd;
      cur_q <= 4'h0; // [R18]
      state_q <= S_EXEC;
      in_ready_q <= 1'b0;
    end
  endtask

  task do_finish;
    begin
      if (f_err != 3'h0)
        fail(f_err);
      else begin
        wr_q <= wr_q + {{(QAW-1){1'b0}}, 1'b1};
        cnt_q <= cnt_q + {{QAW{1'b0}}, 1'b1};
        if (!com_q)
          cur_q <= node_par(f_node); // [R07]
        clr_cmd;
        state_q <= S_CMD;
      end
      if (term)
        terminate; // [R15]
      else if (c == `SCP_CR)
        state_q <= S_CR; // [R17]
    end
  endtask

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= S_CMD;
      buf_q <= 96'h0;
      len_q <= 4'h0;
      cur_q <= 4'h0;
      node_q <= 4'h0;
      com_q <= 1'b0;
      query_q <= 1'b0;
      tany_q <= 1'b0;
      tnum_q <= 1'b0;
      tstop_q <= 1'b0;
      eoi_pend_q <= 1'b0;
      sel_q <= `SCP_S_VAL;
      pcnt_q <= 2'h0;
      val_q <= 16'h0000;
      code_q <= 32'h0;
      wr_q <= {QAW{1'b0}};
      rd_q <= {QAW{1'b0}};
      cnt_q <= {(QAW+1){1'b0}};
      for (k = 0; k < 16; k = k + 1)
        set_q[k] <= lim(k[3:0], `SCP_S_DEF);
      in_ready_q <= 1'b1;
      exec_valid_q <= 1'b0;
      exec_common_q <= 1'b0;
      exec_query_q <= 1'b0;
      exec_node_q <= 4'h0;
      exec_value_q <= 16'h0000;
      exec_pcount_q <= 2'h0;
      exec_code_q <= 32'h0;
      resp_valid_q <= 1'b0;
      resp_data_q <= 16'h0000;
      err_valid_q <= 1'b0;
      err_code_q <= 3'h0;
      err_count_q <= 8'h00;
    end else if (ce) begin
      exec_valid_q <= 1'b0;
      resp_valid_q <= 1'b0;
      err_valid_q <= 1'b0;
      eoi_pend_q <= 1'b0;
      if (take && byte_eoi && byte_data != `SCP_LF) begin
        eoi_pend_q <= 1'b1; // [R16]
        in_ready_q <= 1'b0;
      end
      if (go) begin
        case (state_q)
          S_CMD: begin
            if (c == `SCP_COLON)
              cur_q <= 4'h0; // [R08]
            else if (c == `SCP_STAR) begin
              com_q <= 1'b1; // [R19]
              state_q <= S_KW;
            end else if (is_let(c)) begin
              buf_q <= {buf_q[87:0], c};
              len_q <= 4'h1;
              state_q <= S_KW;
            end else if (term)
              terminate;
            else if (c == `SCP_CR)
              state_q <= S_CR;
            else if (c != `SCP_SP && c != `SCP_SEMI)
              fail(`SCP_E_SYN);
          end
          S_KW: begin
            if (append) begin
              if (len_q == `SCP_KW_MAX)
                fail(`SCP_E_LEN);
              else begin
                buf_q <= {buf_q[87:0], c};
                len_q <= len_q + 4'h1;
              end
            end else if (ends)
              do_finish; // [R20]
            else if (com_q) begin
              if (c == `SCP_SP && com_ok) begin
                code_q <= buf_q[31:0];
                buf_q <= 96'h0;
                len_q <= 4'h0;
                state_q <= S_PAR; // [R19]
              end else
                fail(com_ok ? `SCP_E_SYN : `SCP_E_LEN);
            end else if (hit_w == 4'h0)
              fail(`SCP_E_HDR); // [R03]
            else if (c == `SCP_COLON) begin
              cur_q <= hit_w; // [R04]
              buf_q <= 96'h0;
              len_q <= 4'h0;
            end else if (c == `SCP_QMARK || c == `SCP_SP) begin
              node_q <= hit_w;
              query_q <= c == `SCP_QMARK; // [R12]
              buf_q <= 96'h0;
              len_q <= 4'h0;
              state_q <= c == `SCP_QMARK ? S_QRY : S_PAR;
            end else
              fail(`SCP_E_SYN);
          end
          S_QRY: begin
            if (c == `SCP_SP)
              state_q <= S_PAR;
            else if (ends)
              do_finish;
            else
              fail(`SCP_E_SYN);
          end
          S_PAR: begin
            if (ends)
              do_finish;
            else if (c == `SCP_COMMA) begin
              if (tok_bad)
                fail(`SCP_E_PARAM);
              else begin
                if (first_tok) begin
                  val_q <= tok_val; // [R06]
                  sel_q <= tok_sel;
                end
                pcnt_q <= f_pc;
                buf_q <= 96'h0;
                len_q <= 4'h0;
                tany_q <= 1'b0;
                tnum_q <= 1'b0;
                tstop_q <= 1'b0;
              end
            end else if (is_dig(c) && (!tany_q || tnum_q)) begin
              tany_q <= 1'b1;
              tnum_q <= 1'b1;
              if (!tstop_q && pcnt_q == 2'h0)
                val_q <= (val_q << 3) + (val_q << 1) + {12'h000, c[3:0]};
            end else if (tnum_q)
              tstop_q <= 1'b1;
            else if (is_let(c) && len_q != `SCP_KW_MAX) begin
              buf_q <= {buf_q[87:0], c};
              len_q <= len_q + 4'h1;
              tany_q <= 1'b1;
            end else if (c != `SCP_SP)
              fail(`SCP_E_PARAM);
          end
          S_CR: begin
            if (term)
              terminate; // [R17]
            else
              fail(`SCP_E_SYN);
          end
          S_SKIP: begin
            if (term)
              terminate; // [R21]
          end
          default: begin
          end
        endcase
      end
      if (state_q == S_EXEC) begin
        if (cnt_q == {(QAW+1){1'b0}}) begin
          state_q <= S_CMD;
          in_ready_q <= 1'b1;
        end else begin
          rd_q <= rd_q + {{(QAW-1){1'b0}}, 1'b1}; // [R20]
          cnt_q <= cnt_q - {{QAW{1'b0}}, 1'b1};
          exec_valid_q <= 1'b1;
          exec_common_q <= e[`SCP_EF_COM];
          exec_node_q <= e_node;
          exec_query_q <= e[`SCP_EF_QRY];
          exec_pcount_q <= e[`SCP_EF_PCNT +: 2];
          exec_code_q <= e[31:0];
          exec_value_q <= e_val;
          if (!e[`SCP_EF_COM] && e[`SCP_EF_QRY]) begin
            resp_valid_q <= 1'b1; // [R12]
            resp_data_q <= r_data;
          end else if (!e[`SCP_EF_COM]) begin
            set_q[e_node] <= s_new;
            exec_value_q <= s_new;
          end
        end
      end
    end
  end

  assign in_ready = in_ready_q;
  assign exec_valid = exec_valid_q;
  assign exec_common = exec_common_q;
  assign exec_node = exec_node_q;
  assign exec_query = exec_query_q;
  assign exec_value = exec_value_q;
  assign exec_pcount = exec_pcount_q;
  assign exec_code = exec_code_q;
  assign resp_valid = resp_valid_q;
  assign resp_data = resp_data_q;
  assign err_valid = err_valid_q;
  assign err_code = err_code_q;
  assign err_count = err_count_q;
endmodule // scp_parser

/* File: sim/scp_parser_properties.sv */
`include "scp_consts.vh"
module scp_parser_properties (
  input logic clk,
  input logic reset_n,
  input logic ce,
  input logic byte_valid,
  input logic [7:0] byte_data,
  input logic byte_eoi,
  input logic in_ready,
  input logic exec_valid,
  input logic exec_common,
  input logic exec_query,
  input logic [3:0] exec_node,
  input logic [15:0] exec_value,
  input logic resp_valid,
  input logic [15:0] resp_data,
  input logic err_valid,
  input logic [2:0] err_code,
  input logic [7:0] err_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic taken;
  assign taken = ce && byte_valid && in_ready;
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  resp_is_query_a: assert property (resp_valid |-> exec_valid && exec_query)
    else $error("response without a query entry");
  err_pulse_a: assert property (err_valid && ce |=> !err_valid)
    else $error("error pulse longer than one cycle");
  err_count_step_a: assert property (err_valid && $past(err_count) != 8'hFF |->
    err_count == $past(err_count) + 8'h01)
    else $error("error count did not step");
  err_count_hold_a: assert property (!err_valid |-> $stable(err_count))
    else $error("error count moved without an error");
  err_code_range_a: assert property (err_valid |-> err_code inside {[3'h1:3'h5]})
    else $error("error code out of range");
  term_stall_a: assert property (taken && (byte_data == `SCP_LF || byte_eoi) |=> !in_ready)
    else $error("input not stalled after terminator");
  exec_after_term_a: assert property (exec_valid |-> !in_ready)
    else $error("execution while input open");
  drain_ready_a: assert property ($fell(exec_valid) && ce && $past(ce) |-> in_ready)
    else $error("input not reopened after drain");
  bool_answer_a: assert property (resp_valid && exec_node == `SCP_N_AUTO |->
    resp_data == 16'h0030 || resp_data == 16'h0031)
    else $error("boolean answer not 0 or 1");
  wav_limit_a: assert property (resp_valid && exec_node == `SCP_N_WAV |->
    resp_data inside {[`SCP_WAV_MIN:`SCP_WAV_MAX]})
    else $error("wavelength answer out of limits");
  beam_limit_a: assert property (exec_valid && !exec_common && !exec_query &&
    exec_node == `SCP_N_BEAM |-> exec_value inside {[`SCP_BEAM_MIN:`SCP_BEAM_MAX]})
    else $error("beam setting out of limits");
  cover property (resp_valid && exec_node == `SCP_N_AUTO);
  cover property (err_valid && err_code == `SCP_E_FULL);
  cover property (exec_valid ##1 exec_valid ##1 exec_valid ##1 exec_valid);
endmodule // scp_parser_properties

/* File: sim/scp_host_model.sv */
module scp_host_model (
  input wire logic clk,
  input wire logic in_ready,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic byte_eoi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'hFF;
    byte_eoi = 1'b0;
  end
  // Offers a string byte by byte, each held until a rising edge with in_ready high
  task automatic send(input string s, input bit eoi_last);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clk);
      byte_valid = 1'b1;
      byte_data = s[i];
      byte_eoi = eoi_last && (i == s.len() - 1);
      do @(posedge clk); while (in_ready !== 1'b1);
    end
    @(negedge clk);
    byte_valid = 1'b0;
    byte_eoi = 1'b0;
    byte_data = ~byte_data;
  endtask
endmodule // scp_host_model

/* File: sim/tb_top.sv */
`include "scp_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic byte_valid, byte_eoi, in_ready, exec_valid, exec_common, exec_query;
  logic resp_valid, err_valid;
  logic [7:0] byte_data, err_count;
  logic [3:0] exec_node;
  logic [15:0] exec_value, resp_data;
  logic [1:0] exec_pcount;
  logic [31:0] exec_code;
  logic [2:0] err_code;
  int fail_count = 0;
  int comparisons = 0;
  logic [23:0] xq[$];
  logic [15:0] rq[$];
  logic [2:0] eq[$];
  logic [31:0] cq[$];
  always #10 clk = ~clk;
  scp_parser dut (.clk(clk), .reset_n(reset_n), .ce(ce), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_eoi(byte_eoi), .in_ready(in_ready),
    .exec_valid(exec_valid), .exec_common(exec_common), .exec_node(exec_node),
    .exec_query(exec_query), .exec_value(exec_value), .exec_pcount(exec_pcount),
    .exec_code(exec_code), .resp_valid(resp_valid), .resp_data(resp_data),
    .err_valid(err_valid), .err_code(err_code), .err_count(err_count));
  scp_host_model host (.clk(clk), .in_ready(in_ready), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_eoi(byte_eoi));
  // Collects every pulse the parser emits
  always @(negedge clk) begin
    if (exec_valid === 1'b1) xq.push_back({exec_common, exec_query, exec_pcount, exec_node,
      exec_value});
    if (exec_valid === 1'b1 && exec_common === 1'b1) cq.push_back(exec_code);
    if (resp_valid === 1'b1) rq.push_back(resp_data);
    if (err_valid === 1'b1) eq.push_back(err_code);
  end
  function automatic logic [23:0] sx(input logic [1:0] p, input logic [3:0] n,
    input logic [15:0] v);
    return {2'b00, p, n, v};
  endfunction
  function automatic logic [23:0] qx(input logic [1:0] p, input logic [3:0] n);
    return {2'b01, p, n, 16'h0000};
  endfunction
  function automatic logic [23:0] cx(input logic [1:0] p);
    return {2'b10, p, 20'h00000};
  endfunction
  task automatic print_verdict;
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic fail(input string m);
    fail_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk_x(input logic [23:0] e);
    logic [23:0] m;
    m = e[23] ? 24'hB00000 : (e[22] ? 24'hFF0000 : 24'hFFFFFF);
    comparisons++;
    if (xq.size() == 0 || ((xq.pop_front() ^ e) & m) !== 24'h000000) fail("command entry");
  endtask
  task automatic chk_r(input logic [15:0] e);
    comparisons++;
    if (rq.size() == 0 || rq.pop_front() !== e) fail("query answer");
  endtask
  task automatic chk_e(input logic [2:0] e);
    comparisons++;
    if (eq.size() == 0 || eq.pop_front() !== e) fail("error code");
  endtask
  task automatic chk_c(input logic [31:0] e);
    comparisons++;
    if (cq.size() == 0 || cq.pop_front() !== e) fail("common code");
  endtask
  task automatic chk_cnt(input logic [7:0] e);
    comparisons++;
    if (err_count !== e) fail("error count");
  endtask
  task automatic chk_none;
    comparisons++;
    if (xq.size() + rq.size() + eq.size() + cq.size() != 0) fail("unexpected output");
    xq.delete();
    rq.delete();
    eq.delete();
    cq.delete();
  endtask
  // Waits for the string to drain and the input to reopen
  task automatic settle;
    int k;
    k = 0;
    repeat (3) @(posedge clk);
    while (in_ready !== 1'b1 && k < 30) begin
      @(posedge clk);
      k++;
    end
    if (k == 30) fail("input stuck closed");
    repeat (2) @(posedge clk);
  endtask
  task automatic cmd(input string s);
    host.send(s, 1'b0);
    settle;
  endtask
  task automatic t_forms;
    cmd("CORR:WAV 500\n");
    chk_x(sx(2'h1, `SCP_N_WAV, 16'h01F4));
    cmd("sens:correction:wavelength 700\n");
    chk_x(sx(2'h1, `SCP_N_WAV, 16'h02BC));
    cmd("Corr:Wav?\n");
    chk_x(qx(2'h0, `SCP_N_WAV));
    chk_r(16'h02BC);
    cmd("CORR:WAVEL 500\n");
    chk_e(`SCP_E_HDR);
    cmd("COR:WAV 500\n");
    chk_e(`SCP_E_HDR);
    cmd("CORR:WAV?\n");
    chk_x(qx(2'h0, `SCP_N_WAV));
    chk_r(16'h02BC);
    chk_none;
  endtask
  task automatic t_semi;
    cmd("CORR:BEAM 7;WAV 450\n");
    chk_x(sx(2'h1, `SCP_N_BEAM, 16'h0007));
    chk_x(sx(2'h1, `SCP_N_WAV, 16'h01C2));
    cmd("CORR:BEAM 8;:AVER 300\n");
    chk_x(sx(2'h1, `SCP_N_BEAM, 16'h0008));
    chk_x(sx(2'h1, `SCP_N_AVER, 16'h012C));
    cmd("CORR:BEAM 9;AVER 3\n");
    chk_x(sx(2'h1, `SCP_N_BEAM, 16'h0009));
    chk_e(`SCP_E_HDR);
    cmd("AVER 12,34\n");
    chk_x(sx(2'h2, `SCP_N_AVER, 16'h000C));
    chk_none;
  endtask
  task automatic t_limits;
    cmd("CORR:BEAM\n");
    chk_x(sx(2'h0, `SCP_N_BEAM, `SCP_BEAM_DEF));
    cmd("CORR:BEAM MAX\n");
    chk_x(sx(2'h1, `SCP_N_BEAM, `SCP_BEAM_MAX));
    cmd("corr:beam min\n");
    chk_x(sx(2'h1, `SCP_N_BEAM, `SCP_BEAM_MIN));
    cmd("CORR:BEAM DEF\n");
    chk_x(sx(2'h1, `SCP_N_BEAM, `SCP_BEAM_DEF));
    cmd("CORR:BEAM FOO\n");
    chk_e(`SCP_E_PARAM);
    cmd("CORR:WAV MIN\n");
    chk_x(sx(2'h1, `SCP_N_WAV, `SCP_WAV_MIN));
    cmd("CORR:WAV? MAX\n");
    chk_x(qx(2'h1, `SCP_N_WAV));
    chk_r(`SCP_WAV_MAX);
    cmd("CORR:WAV?\n");
    chk_x(qx(2'h0, `SCP_N_WAV));
    chk_r(`SCP_WAV_MIN);
    chk_none;
  endtask
  task automatic t_term;
    host.send("CORR:BEAM 4", 1'b0);
    settle;
    chk_none;
    @(negedge clk) ce = 1'b0;
    cmd("\n");
    chk_none;
    @(negedge clk) ce = 1'b1;
    cmd("\n");
    chk_x(sx(2'h1, `SCP_N_BEAM, 16'h0004));
    cmd("WAV 600\n");
    chk_e(`SCP_E_HDR);
    host.send("CORR:BEAM 6", 1'b1);
    settle;
    chk_x(sx(2'h1, `SCP_N_BEAM, 16'h0006));
    cmd("CORR:BEAM 2\r\n");
    chk_x(sx(2'h1, `SCP_N_BEAM, 16'h0002));
    cmd("CORR:BEAM 3\rX\n");
    chk_x(sx(2'h1, `SCP_N_BEAM, 16'h0003));
    chk_e(`SCP_E_SYN);
    chk_none;
  endtask
  task automatic t_common;
    cmd("*RST;*CLS;*ESE 32;*OPC?\n");
    chk_x(cx(2'h0));
    chk_x(cx(2'h0));
    chk_x(cx(2'h1));
    chk_x(cx(2'h0));
    chk_c(32'h00525354);
    chk_c(32'h00434C53);
    chk_c(32'h00455345);
    chk_c(32'h4F50433F);
    cmd("*AB\n");
    chk_e(`SCP_E_LEN);
    cmd("*ABCDE\n");
    chk_e(`SCP_E_LEN);
    cmd("*CLS;*CLS;*CLS;*CLS;*CLS\n");
    for (int i = 0; i < 4; i++) begin
      chk_x(cx(2'h0));
      chk_c(32'h00434C53);
    end
    chk_e(`SCP_E_FULL);
    chk_none;
  endtask
  task automatic t_bool;
    cmd("CURR:DC:RANG:AUTO OFF\n");
    chk_x(sx(2'h1, `SCP_N_AUTO, 16'h0000));
    cmd("curr:rang:auto?\n");
    chk_x(qx(2'h0, `SCP_N_AUTO));
    chk_r(16'h0030);
    cmd("CURRENT:RANGE:AUTO ON\n");
    chk_x(sx(2'h1, `SCP_N_AUTO, 16'h0001));
    cmd("CURR:RANG:AUTO?\n");
    chk_x(qx(2'h0, `SCP_N_AUTO));
    chk_r(16'h0031);
    cmd("CURR?\n");
    chk_e(`SCP_E_HDR);
    chk_none;
    chk_cnt(8'h0A);
  endtask
  task automatic t_reset;
    @(negedge clk);
    reset_n = 1'b0;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    cmd("CORR:BEAM?\n");
    chk_x(qx(2'h0, `SCP_N_BEAM));
    chk_r(`SCP_BEAM_DEF);
    chk_none;
    chk_cnt(8'h00);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    t_forms;
    t_semi;
    t_limits;
    t_term;
    t_common;
    t_bool;
    t_reset;
    print_verdict;
  end
  initial begin
    #100000;
    fail("watchdog expired");
    print_verdict;
  end
endmodule // tb_top
bind scp_parser scp_parser_properties u_props (.clk(clk), .reset_n(reset_n), .ce(ce),
  .byte_valid(byte_valid), .byte_data(byte_data), .byte_eoi(byte_eoi), .in_ready(in_ready),
  .exec_valid(exec_valid), .exec_common(exec_common), .exec_query(exec_query),
  .exec_node(exec_node), .exec_value(exec_value), .resp_valid(resp_valid),
  .resp_data(resp_data), .err_valid(err_valid), .err_code(err_code), .err_count(err_count));
